/* shared/rail_seq_pkg.sv */
// constants shared by the rail strobe sequencer and its interval timer
// assumes a single 20 MHz clock and a host register port on the same clock
`default_nettype none
package rail_seq_pkg;
    // register offsets and reset values
    localparam logic [7:0] MAP_B_OFF = 8'h23;
    localparam logic [7:0] BACKUP_OFF = 8'h24;
    localparam logic [7:0] MAP_B_RESET = 8'h8a;
    localparam logic [7:0] BACKUP_RESET = 8'h12;
    localparam logic [7:0] BACKUP_WMASK = 8'h33; // writable bits only
    // field positions
    localparam int BUCKBOOST_LSB = 4;
    localparam int THIRD_BUCK_LSB = 0;
    localparam int BACKUP_1V8_LSB = 4;
    localparam int BACKUP_1V0_LSB = 0;
    // strobe codes
    localparam logic [3:0] MAIN_CODE_MIN = 4'h3;
    localparam logic [3:0] MAIN_CODE_MAX = 4'ha;
    localparam logic [1:0] BACKUP_CODE_S1 = 2'h1;
    localparam logic [1:0] BACKUP_CODE_S2 = 2'h2;
    localparam logic [3:0] FIRST_STROBE = 4'h1;
    localparam logic [3:0] LAST_STROBE = 4'ha;
    localparam logic [3:0] SEALED_STROBE_MAX = 4'h2;
    // rail enable bit positions
    localparam int RAIL_THIRD_BUCK = 0;
    localparam int RAIL_BUCKBOOST = 1;
    localparam int RAIL_BACKUP_1V0 = 2;
    localparam int RAIL_BACKUP_1V8 = 3;
    localparam int RAIL_COUNT = 4;
    // timing
    localparam int CLK_FREQ_HZ = 20000000;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES = CLK_FREQ_HZ / 1000 * TICK_MS;
    localparam logic [6:0] SHORT_INTERVAL_MS = 7'd2;
    localparam logic [6:0] LONG_INTERVAL_MS = 7'd5;
    localparam logic [6:0] POWERDOWN_FACTOR = 7'd10;
    // sequencer states, gray along idle -> strobe -> wait
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_STROBE = 2'b01,
        SEQ_WAIT = 2'b11
    } seq_state_t;
endpackage : rail_seq_pkg
`default_nettype wire

/* shared/strobe_timer_if.sv */
// request and answer between the sequencer and its interval timer
// assumes both ends sit on the same clock
`default_nettype none
interface strobe_timer_if;
    logic start;     // one-cycle pulse
    logic long_sel;  // 5 ms instead of 2 ms
    logic times_ten; // power-down stretch
    logic done;      // one-cycle pulse
    modport seq (output start, output long_sel, output times_ten,
                 input done);
    modport timer (input start, input long_sel, input times_ten,
                   output done);
endinterface : strobe_timer_if
`default_nettype wire

/* rtl/strobe_timer.sv */
// inter-strobe interval timer: millisecond tick divider and ms countdown
// assumes start is a one-cycle pulse from the sequencer on the same clock
`default_nettype none
module strobe_timer #(
    parameter int TICK_CYCLES = rail_seq_pkg::MS_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    strobe_timer_if.timer tif
);
    import rail_seq_pkg::*;

    localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    typedef struct packed {
        logic [PW-1:0] pre;
        logic [6:0] ms;
        logic busy;
        logic done;
    } timer_state_t;

    timer_state_t s;
    timer_state_t next_s;
    logic [6:0] target_ms;

    // interval length, stretched tenfold only when asked
    always_comb begin
        target_ms = tif.long_sel ? LONG_INTERVAL_MS
                                 : SHORT_INTERVAL_MS;
        if (tif.times_ten) begin
            target_ms = 7'(target_ms * POWERDOWN_FACTOR);
        end
    end

    // prescaler gives a 1 ms enable; the ms counter runs on that enable
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        if (tif.start) begin
            next_s.pre = '0;
            next_s.ms = target_ms;
            next_s.busy = 1'b1;
        end else if (s.busy) begin
            if (s.pre == PW'(TICK_CYCLES - 1)) begin
                next_s.pre = '0;
                if (s.ms == 7'h01) begin
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                end else begin
                    next_s.ms = s.ms - 7'h01;
                end
            end else begin
                next_s.pre = s.pre + PW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tif.done = s.done;

    // helper: busy cycles since start and the interval that was asked
    int cyc_count;
    int exp_ms;
    always_ff @(posedge clk) begin
        if (rst) begin
            cyc_count <= 0;
            exp_ms <= 0;
        end else if (tif.start) begin
            cyc_count <= 0;
            exp_ms <= int'(target_ms);
        end else if (s.busy) begin
            cyc_count <= cyc_count + 1;
        end
    end

    a_interval_exact: assert property (@(posedge clk) disable iff (rst)
        s.done |-> cyc_count == exp_ms * TICK_CYCLES)
        else $error("interval length wrong");
    a_powerdown_stretch: assert property (@(posedge clk) disable iff (rst)
        tif.start && tif.times_ten |=> s.ms == 7'd20 || s.ms == 7'd50)
        else $error("power-down interval not stretched");
endmodule : strobe_timer
`default_nettype wire

/* rtl/rail_strobe_assignment.sv */
// rail strobe assignment registers and the strobe sequencer they steer
// assumes the host register port and the request inputs are on clk
`default_nettype none
module rail_strobe_assignment #(
    parameter int TICK_CYCLES = rail_seq_pkg::MS_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic power_up_req,
    input wire logic power_down_req,
    input wire logic freshness_seal_flag,
    input wire logic [9:1] strobe_interval_sel,
    input wire logic powerdown_delay_multiplier,
    output logic [rail_seq_pkg::RAIL_COUNT-1:0] rail_en,
    output logic [3:0] current_strobe,
    output logic seq_busy
);
    import rail_seq_pkg::*;

    typedef struct packed {
        seq_state_t st;
        logic down;
        logic [3:0] strobe;
        logic [RAIL_COUNT-1:0] rails;
        logic [7:0] main_rail_strobe_map_b;
        logic [7:0] backup_rail_strobe_map;
        logic [7:0] rdata;
        logic tstart;
        logic tlong;
        logic tx10;
    } seq_state_full_t;

    seq_state_full_t s;
    seq_state_full_t next_s;
    strobe_timer_if tif ();

    strobe_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
        .clk(clk),
        .rst(rst),
        .tif(tif)
    );

    logic [3:0] buckboost_rail_strobe_sel;
    logic [3:0] third_buck_strobe_sel;
    logic [1:0] backup_1v8_strobe_sel;
    logic [1:0] backup_1v0_strobe_sel;
    assign buckboost_rail_strobe_sel =
        s.main_rail_strobe_map_b[BUCKBOOST_LSB +: 4];
    assign third_buck_strobe_sel =
        s.main_rail_strobe_map_b[THIRD_BUCK_LSB +: 4];
    assign backup_1v8_strobe_sel =
        s.backup_rail_strobe_map[BACKUP_1V8_LSB +: 2];
    assign backup_1v0_strobe_sel =
        s.backup_rail_strobe_map[BACKUP_1V0_LSB +: 2];

    // does a main code select this strobe (3h..Ah only)
    function automatic logic main_hit(input logic [3:0] code,
                                      input logic [3:0] stb);
        main_hit = code >= MAIN_CODE_MIN && code <= MAIN_CODE_MAX
                   && code == stb;
    endfunction : main_hit

    // backup code 1h or 2h selects strobe 1 or 2; 0h and 3h never do
    function automatic logic backup_hit(input logic [1:0] code,
                                        input logic [3:0] stb);
        backup_hit = (code == BACKUP_CODE_S1 || code == BACKUP_CODE_S2)
                     && {2'h0, code} == stb;
    endfunction : backup_hit

    logic skipped;
    logic last;
    logic [3:0] nxt_strobe;
    logic [3:0] dly_idx;

    // register port, strobe walk and timer requests
    always_comb begin
        next_s = s;
        next_s.tstart = 1'b0;
        skipped = freshness_seal_flag && s.strobe <= SEALED_STROBE_MAX;
        last = s.down ? (s.strobe == FIRST_STROBE) : (s.strobe == LAST_STROBE);
        nxt_strobe = s.down ? s.strobe - 4'h1 : s.strobe + 4'h1;
        dly_idx = s.down ? s.strobe - 4'h1 : s.strobe;
        if (dly_idx < 4'h1 || dly_idx > 4'h9) begin
            dly_idx = 4'h1; // only reached on the last strobe or at strobe 0 after reset, never used
        end
        if (reg_wr) begin
            if (reg_addr == MAP_B_OFF) begin
                next_s.main_rail_strobe_map_b = reg_wdata;
            end else if (reg_addr == BACKUP_OFF) begin
                next_s.backup_rail_strobe_map = reg_wdata & BACKUP_WMASK;
            end
        end
        if (reg_rd) begin
            // unmapped offsets read as zero
            if (reg_addr == MAP_B_OFF) begin
                next_s.rdata = s.main_rail_strobe_map_b;
            end else if (reg_addr == BACKUP_OFF) begin
                next_s.rdata = s.backup_rail_strobe_map;
            end else begin
                next_s.rdata = 8'h00;
            end
        end
        unique case (s.st)
            SEQ_IDLE: begin
                // up wins if both arrive together
                if (power_up_req) begin
                    next_s.down = 1'b0;
                    next_s.strobe = FIRST_STROBE;
                    next_s.st = SEQ_STROBE;
                end else if (power_down_req) begin
                    next_s.down = 1'b1;
                    next_s.strobe = LAST_STROBE;
                    next_s.st = SEQ_STROBE;
                end
            end
            SEQ_STROBE: begin
                if (!skipped) begin
                    if (main_hit(third_buck_strobe_sel, s.strobe)) begin
                        next_s.rails[RAIL_THIRD_BUCK] = !s.down;
                    end
                    if (main_hit(buckboost_rail_strobe_sel, s.strobe)) begin
                        next_s.rails[RAIL_BUCKBOOST] = !s.down;
                    end
                    // a broken seal keeps the backup rails on
                    if (backup_hit(backup_1v0_strobe_sel, s.strobe)
                        && !(s.down && freshness_seal_flag)) begin
                        next_s.rails[RAIL_BACKUP_1V0] = !s.down;
                    end
                    if (backup_hit(backup_1v8_strobe_sel, s.strobe)
                        && !(s.down && freshness_seal_flag)) begin
                        next_s.rails[RAIL_BACKUP_1V8] = !s.down;
                    end
                end
                if (last) begin
                    next_s.st = SEQ_IDLE;
                end else if (skipped) begin
                    next_s.strobe = nxt_strobe; // no gap after a skipped strobe
                end else begin
                    next_s.tstart = 1'b1;
                    next_s.tlong = strobe_interval_sel[dly_idx];
                    next_s.tx10 = s.down && powerdown_delay_multiplier;
                    next_s.st = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (tif.done) begin
                    next_s.strobe = nxt_strobe;
                    next_s.st = SEQ_STROBE;
                end
            end
            default: begin
                next_s.st = SEQ_IDLE;
            end
        endcase
    end

    // state register, documented reset values on the map registers
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.st <= SEQ_IDLE;
            s.main_rail_strobe_map_b <= MAP_B_RESET;
            s.backup_rail_strobe_map <= BACKUP_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign tif.start = s.tstart;
    assign tif.long_sel = s.tlong;
    assign tif.times_ten = s.tx10;
    assign reg_rdata = s.rdata;
    assign rail_en = s.rails;
    assign current_strobe = s.strobe;
    assign seq_busy = s.st != SEQ_IDLE;

    sequence strobe_up_at(logic [3:0] k);
        s.st == SEQ_STROBE && !s.down && s.strobe == k && !skipped;
    endsequence
    sequence strobe_any;
        s.st == SEQ_STROBE && !skipped;
    endsequence

    a_reset_maps: assert property (@(posedge clk)
        $past(rst) |-> s.main_rail_strobe_map_b == 8'h8a
                   && s.backup_rail_strobe_map == 8'h12)
        else $error("map registers not at reset values");
    a_reset_fields: assert property (@(posedge clk)
        $past(rst) |-> buckboost_rail_strobe_sel == 4'h8
                   && third_buck_strobe_sel == 4'ha)
        else $error("main rail fields not at reset codes");
    a_main_enable: assert property (@(posedge clk) disable iff (rst)
        strobe_up_at(buckboost_rail_strobe_sel) ##0
        (buckboost_rail_strobe_sel >= 4'h3 && buckboost_rail_strobe_sel <= 4'h9)
        |=> rail_en[RAIL_BUCKBOOST])
        else $error("buckboost rail missed its strobe");
    a_code_ten: assert property (@(posedge clk) disable iff (rst)
        strobe_up_at(4'ha) ##0 third_buck_strobe_sel == 4'ha
        |=> rail_en[RAIL_THIRD_BUCK])
        else $error("third buck rail missed strobe 10");
    a_main_uncontrolled: assert property (@(posedge clk) disable iff (rst)
        (third_buck_strobe_sel < 4'h3 || third_buck_strobe_sel > 4'ha)
        |=> $stable(rail_en[RAIL_THIRD_BUCK]))
        else $error("uncontrolled main rail changed");
    a_backup_s1: assert property (@(posedge clk) disable iff (rst)
        strobe_up_at(4'h1) ##0 backup_1v0_strobe_sel == 2'h1
        |=> rail_en[RAIL_BACKUP_1V0])
        else $error("backup 1v0 rail missed strobe 1");
    a_backup_s2: assert property (@(posedge clk) disable iff (rst)
        strobe_up_at(4'h2) ##0 backup_1v8_strobe_sel == 2'h2
        |=> rail_en[RAIL_BACKUP_1V8])
        else $error("backup 1v8 rail missed strobe 2");
    a_backup_uncontrolled: assert property (@(posedge clk) disable iff (rst)
        (backup_1v8_strobe_sel == 2'h0 || backup_1v8_strobe_sel == 2'h3)
        |=> $stable(rail_en[RAIL_BACKUP_1V8]))
        else $error("uncontrolled backup rail changed");
    a_sealed_skip: assert property (@(posedge clk) disable iff (rst)
        s.st == SEQ_STROBE && s.strobe <= 4'h2 && freshness_seal_flag
        |=> $stable(rail_en) && s.st != SEQ_WAIT)
        else $error("sealed strobe 1 or 2 executed");
    a_backup_kept: assert property (@(posedge clk) disable iff (rst)
        freshness_seal_flag && rail_en[RAIL_BACKUP_1V0]
        |=> rail_en[RAIL_BACKUP_1V0])
        else $error("backup rail disabled after seal broken");
    // the end of every gap must land on the neighbouring strobe
    a_walk_order: assert property (@(posedge clk)
        disable iff (rst) s.st == SEQ_WAIT && tif.done
        |=> s.st == SEQ_STROBE
            && s.strobe == (s.down ? $past(s.strobe) - 4'h1
                                   : $past(s.strobe) + 4'h1))
        else $error("strobe walk out of order");
    a_gap_start: assert property (@(posedge clk)
        disable iff (rst) strobe_any ##0 !last
        |=> s.st == SEQ_WAIT && tif.start)
        else $error("gap not started after a strobe");
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        s.backup_rail_strobe_map[7:6] == 2'h0
        && s.backup_rail_strobe_map[3:2] == 2'h0)
        else $error("reserved backup map bits not zero");
endmodule : rail_strobe_assignment
`default_nettype wire

/* verif/host_bus_model.sv */
// host side of the byte register port: single byte reads and writes
// assumes the device samples the port on the rising edge of clk
`default_nettype none
module host_bus_model (
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic clk
);
    timeunit 1ns;
    timeprecision 1ns;

    // quiet port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one strobe cycle, then the lines carry the inverse so that a stale
    // address or byte can never pass for a live one
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : xfer
endmodule : host_bus_model
`default_nettype wire

/* verif/rail_strobe_assignment_test.sv */
// self-checking bench for the rail strobe map registers and sequencer
// assumes a shortened millisecond tick and the host model beside it
`default_nettype none
module rail_strobe_assignment_test;
    timeunit 1ns;
    timeprecision 1ns;
    import rail_seq_pkg::*;
    localparam int TICK = 4;
    logic clk, rst, wr, rd, up_req, down_req, seal, mult, busy, rd_seen;
    logic [7:0] addr, wdata, rdata, ma, mb;
    logic [9:1] isel;
    logic [3:0] rail_en, strobe, mrail, last_rail;
    int seed = 32'h422e;
    logic [7:0] rd_q[$];
    logic [39:0] ev_q[$];
    int failures = 0, comparisons = 0, cyc = 0, last_ev = -1, n, gap;

    host_bus_model host (.reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
                         .reg_rd(rd), .clk(clk));
    rail_strobe_assignment #(.TICK_CYCLES(TICK)) DUT (
        .clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .power_up_req(up_req), .power_down_req(down_req),
        .freshness_seal_flag(seal), .strobe_interval_sel(isel),
        .powerdown_delay_multiplier(mult), .rail_en(rail_en),
        .current_strobe(strobe), .seq_busy(busy));

    // free-running clock and edge counter for gap measurement
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge clk) rd_seen <= rd;

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check

    task automatic summarize;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // watcher: read data and every rail change against the oldest note
    always @(negedge clk) begin
        if (rd_seen && rd_q.size() > 0)
            check(rdata, rd_q.pop_front());
        if (rst) begin
            last_rail = 4'h0;
        end else if (rail_en !== last_rail) begin
            // own variable: the walk's wait loop counts in n meanwhile
            gap = (last_ev < 0) ? 0 : cyc - last_ev;
            last_ev = cyc;
            check({32'(gap), strobe, rail_en},
                  ev_q.size() ? ev_q.pop_front() : 40'h0);
            last_rail = rail_en;
        end
    end

    // notes the rail changes of one walk with the cycles between them
    task automatic walk(input bit up);
        int k, nk, cost;
        bit first;
        logic [3:0] want, nr;
        cost = 0;
        first = 1'b1;
        for (int i = 0; i < 10; i++) begin
            k = up ? i + 1 : 10 - i;
            // sealed low strobes are skipped, so backups stay as they are
            if (!(seal && k <= 2)) begin
                want = (k <= 2) ? {mb[5:4] == k, mb[1:0] == k, 2'b00}
                     : {2'b00, ma[7:4] == k, ma[3:0] == k};
                nr = up ? (mrail | want) : (mrail & ~want);
                if (nr !== mrail) begin
                    ev_q.push_back({first ? 32'd0 : 32'(cost), k[3:0], nr});
                    cost = 0;
                    first = 1'b0;
                    mrail = nr;
                end
            end
            nk = up ? k + 1 : k - 1;
            // a gap costs its ms, one cycle to start the timer and two
            // for done to come back; a skipped strobe itself costs one cycle
            if (i < 9)
                cost += (seal && k <= 2) ? 1
                      : (isel[up ? k : nk] ? 5 : 2) * TICK
                        * ((!up && mult) ? 10 : 1) + 3;
        end
        last_ev = -1;
        // up walk sends both requests at once: power-up must take priority
        @(posedge clk);
        #1;
        up_req = up;
        down_req = 1'b1;
        @(posedge clk);
        #1;
        up_req = 1'b0;
        down_req = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check(busy, 1'b1);
        // a request while busy is ignored
        up_req = !up;
        down_req = up;
        @(posedge clk);
        #1;
        up_req = 1'b0;
        down_req = 1'b0;
        for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk);
        if (n == 3000) begin
            failures++;
            summarize();
        end
        repeat (2) @(posedge clk);
        #1;
        check(40'(ev_q.size()), 40'h0);
    endtask : walk

    initial begin
        rst = 1'b1;
        up_req = 1'b0;
        down_req = 1'b0;
        seal = 1'b0;
        mult = 1'b0;
        isel = 9'h000;
        mrail = 4'h0;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        // reset values, an unmapped offset and the reserved backup bits
        rd_q.push_back(MAP_B_RESET);
        host.xfer(1'b0, MAP_B_OFF, 8'h00);
        rd_q.push_back(BACKUP_RESET);
        host.xfer(1'b0, BACKUP_OFF, 8'h00);
        host.xfer(1'b1, 8'h25, 8'hff);
        rd_q.push_back(8'h00);
        host.xfer(1'b0, 8'h25, 8'h00);
        host.xfer(1'b1, BACKUP_OFF, 8'hff);
        rd_q.push_back(8'h33);
        host.xfer(1'b0, BACKUP_OFF, 8'h00);
        $display("test registers done");
        // every field code, seal broken part way, random gaps
        for (int i = 0; i < 16; i++) begin
            ma = {4'(15 - i), 4'(i)};
            mb = {2'b00, 2'(i >> 1), 2'b00, 2'(i)};
            isel = 9'($random(seed));
            mult = 1'($random(seed));
            host.xfer(1'b1, MAP_B_OFF, ma);
            host.xfer(1'b1, BACKUP_OFF, mb | (8'($random(seed)) & 8'hcc));
            rd_q.push_back(ma);
            host.xfer(1'b0, MAP_B_OFF, 8'h00);
            rd_q.push_back(mb);
            host.xfer(1'b0, BACKUP_OFF, 8'h00);
            seal = (i >= 12);
            walk(1'b1);
            seal = (i >= 8);
            walk(1'b0);
            $display("test walk %0d done", i);
        end
        summarize();
    end
endmodule : rail_strobe_assignment_test
`default_nettype wire
